//--- design/quiet_pwm_defines.svh
`ifndef QUIET_PWM_DEFINES_SVH
`define QUIET_PWM_DEFINES_SVH

`define STATUS_OFFSET      7'h6f
`define CONFIG_OFFSET      7'h70

`define CFG_LIM_MSB        31
`define CFG_LIM_LSB        28
`define CFG_REG_MSB        27
`define CFG_REG_LSB        24
`define CFG_FREEWHEEL_MSB  21
`define CFG_FREEWHEEL_LSB  20
`define CFG_AUTOGRAD_BIT   19
`define CFG_AUTOSCALE_BIT  18
`define CFG_FREQ_MSB       17
`define CFG_FREQ_LSB       16
`define CFG_GRAD_MSB       15
`define CFG_GRAD_LSB       8
`define CFG_OFS_MSB        7
`define CFG_OFS_LSB        0
`define CFG_WRITE_MASK     32'hff3f_ffff

`define CFG_LIM_RESET      4'hc
`define CFG_REG_RESET      4'h4
`define CFG_FREQ_RESET     2'h1
`define CFG_OFS_RESET      8'h24

`define STS_STANDSTILL_BIT 31
`define STS_QUIET_BIT      30
`define STS_CS_MSB         20
`define STS_CS_LSB         16
`define STS_TEMP_HIGH_BIT  11
`define STS_TEMP_MID_BIT   10

`define PERIOD_CODE_00     11'h400
`define PERIOD_CODE_01     11'h2ab
`define PERIOD_CODE_10     11'h200
`define PERIOD_CODE_11     11'h19a
`define PHASE_STEP         11'h002

`define STANDSTILL_CLOCKS  21'h10_0000
`define LOW_REG_FLOOR      8'h10

`endif

//--- design/quiet_pwm_pkg.sv
package quiet_pwm_pkg;

  typedef struct packed {
    logic [6:0]  addr;
    logic        wr;
    logic [31:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic [1:0]  step_sync;
    logic        step_prev;
    logic [1:0]  temp_high_sync;
    logic [1:0]  temp_mid_sync;
    logic        otp_loaded;
    logic [31:0] config_word;
    logic [20:0] idle_count;
    logic [20:0] step_interval;
    logic [10:0] phase;
    logic        period_start;
    logic [7:0]  amplitude;
    logic        pwm_level;
    logic [31:0] rdata;
  } state_type;

endpackage

//--- design/amplitude_calc.sv
`timescale 1ns/100ps
`include "quiet_pwm_defines.svh"
module amplitude_calc (
  input  wire logic [7:0]  offset_i,
  input  wire logic [7:0]  gradient_i,
  input  wire logic [4:0]  current_scale_i,
  input  wire logic [20:0] step_interval_i,
  input  wire logic        autoscale_i,
  input  wire logic [7:0]  auto_amplitude_i,
  input  wire logic [7:0]  floor_i,
  output logic      [7:0]  amplitude_o
);

  logic [13:0] scaled_offset;
  logic [20:0] grad_term;
  logic [21:0] feed_forward;

  always_comb begin
    scaled_offset = offset_i * ({1'b0, current_scale_i} + 6'h01);
    // a zero interval means no step seen yet or standstill, so no back-emf term
    if (step_interval_i == 21'h00_0000) begin
      grad_term = 21'h00_0000;
    end else begin
      grad_term = {5'h00, gradient_i, 8'h00} / step_interval_i;
    end
    feed_forward = {13'h0000, scaled_offset[13:5]} + {1'b0, grad_term};
    if (!autoscale_i) begin
      amplitude_o = (feed_forward > 22'h00_00ff) ? 8'hff : feed_forward[7:0];
    end else if (offset_i == 8'h00 && auto_amplitude_i < floor_i) begin
      amplitude_o = floor_i;
    end else begin
      amplitude_o = auto_amplitude_i;
    end
  end

endmodule

//--- design/quiet_pwm_amplitude_and_status.sv
`timescale 1ns/100ps
`include "quiet_pwm_defines.svh"
module quiet_pwm_amplitude_and_status #(
  parameter logic [20:0] STANDSTILL_CLOCKS = `STANDSTILL_CLOCKS,
  parameter logic [7:0]  LOW_REG_FLOOR     = `LOW_REG_FLOOR
) (
  input  wire logic                        mclk_i,
  input  wire logic                        reset_i,
  input  wire quiet_pwm_pkg::reg_req_type  reg_req_i,
  output logic      [31:0]                 reg_rdata_o,
  input  wire logic                        step_pulse_i,
  input  wire logic                        temp_high_flag_i,
  input  wire logic                        temp_mid_flag_i,
  input  wire logic [7:0]                  otp_gradient_i,
  input  wire logic                        quiet_chopper_active_i,
  input  wire logic [4:0]                  current_scale_i,
  input  wire logic [7:0]                  auto_amplitude_i,
  output logic      [7:0]                  amplitude_sum_o,
  output logic                             pwm_o,
  output logic                             pwm_period_start_o,
  output logic                             standstill_o,
  output logic      [1:0]                  freewheel_mode_o,
  output logic                             autoscale_o,
  output logic                             autograd_o,
  output logic      [3:0]                  regulation_gradient_o,
  output logic      [3:0]                  switch_on_limit_o
);

  quiet_pwm_pkg::state_type state_reg;
  quiet_pwm_pkg::state_type state_next;

  logic [7:0]  amplitude_comb;
  logic [10:0] period_len;
  logic [11:0] phase_sum;
  logic        step_edge;
  logic        standstill;
  logic [31:0] status_word;

  // phase length per frequency code, twice the period in clocks; phase advances by two per clock
  function automatic logic [10:0] period_of(input logic [1:0] code);
    logic [10:0] len;
    len = `PERIOD_CODE_00;
    if (code == 2'h1) begin
      len = `PERIOD_CODE_01;
    end else if (code == 2'h2) begin
      len = `PERIOD_CODE_10;
    end else if (code == 2'h3) begin
      len = `PERIOD_CODE_11;
    end
    return len;
  endfunction

  amplitude_calc u_amplitude_calc (
    .offset_i         (state_reg.config_word[`CFG_OFS_MSB:`CFG_OFS_LSB]),
    .gradient_i       (state_reg.config_word[`CFG_GRAD_MSB:`CFG_GRAD_LSB]),
    .current_scale_i  (current_scale_i),
    .step_interval_i  (state_reg.step_interval),
    .autoscale_i      (state_reg.config_word[`CFG_AUTOSCALE_BIT]),
    .auto_amplitude_i (auto_amplitude_i),
    .floor_i          (LOW_REG_FLOOR),
    .amplitude_o      (amplitude_comb)
  );

  always_comb begin
    state_next = state_reg;

    // pins pass two flops; only the second stage is read beyond here
    state_next.step_sync      = {state_reg.step_sync[0], step_pulse_i};
    state_next.temp_high_sync = {state_reg.temp_high_sync[0], temp_high_flag_i};
    state_next.temp_mid_sync  = {state_reg.temp_mid_sync[0], temp_mid_flag_i};
    state_next.step_prev      = state_reg.step_sync[1];
    step_edge = state_reg.step_sync[1] & ~state_reg.step_prev;

    // idle counter saturates so standstill holds until the next step
    if (step_edge) begin
      state_next.idle_count = 21'h00_0000;
    end else if (state_reg.idle_count < STANDSTILL_CLOCKS) begin
      state_next.idle_count = state_reg.idle_count + 21'h00_0001;
    end
    standstill = (state_reg.idle_count >= STANDSTILL_CLOCKS);

    // interval is the idle count plus one at each step; standstill makes the term vanish
    if (step_edge) begin
      state_next.step_interval = state_reg.idle_count + 21'h00_0001;
    end else if (standstill) begin
      state_next.step_interval = 21'h00_0000;
    end

    // fractional divider: phase accumulates 2 per clock modulo the code length
    period_len = period_of(state_reg.config_word[`CFG_FREQ_MSB:`CFG_FREQ_LSB]);
    phase_sum  = {1'b0, state_reg.phase} + {1'b0, `PHASE_STEP};
    if (phase_sum >= {1'b0, period_len}) begin
      state_next.phase        = 11'(phase_sum - {1'b0, period_len});
      // a shorter code chosen mid-period restarts the phase, one wrap only
      if (state_next.phase >= period_len) begin
        state_next.phase = 11'h000;
      end
      state_next.period_start = 1'b1;
    end else begin
      state_next.phase        = phase_sum[10:0];
      state_next.period_start = 1'b0;
    end

    // amplitude only changes at a period boundary to avoid mid-cycle glitches
    if (state_reg.period_start) begin
      state_next.amplitude = amplitude_comb;
    end
    state_next.pwm_level = ({state_reg.phase, 8'h00} <
                            19'(state_reg.amplitude * period_len));

    // one-time gradient is taken once, on the first edge after reset release
    if (!state_reg.otp_loaded) begin
      state_next.otp_loaded = 1'b1;
      state_next.config_word[`CFG_GRAD_MSB:`CFG_GRAD_LSB] = otp_gradient_i;
    end else if (reg_req_i.wr && reg_req_i.addr == `CONFIG_OFFSET) begin
      state_next.config_word = reg_req_i.wdata & `CFG_WRITE_MASK;
    end
    // writes to the status offset fall through with no effect

    status_word = 32'h0000_0000;
    status_word[`STS_STANDSTILL_BIT]      = standstill;
    status_word[`STS_QUIET_BIT]           = quiet_chopper_active_i;
    status_word[`STS_CS_MSB:`STS_CS_LSB]  = current_scale_i;
    status_word[`STS_TEMP_HIGH_BIT]       = state_reg.temp_high_sync[1];
    status_word[`STS_TEMP_MID_BIT]        = state_reg.temp_mid_sync[1];

    if (reg_req_i.addr == `STATUS_OFFSET) begin
      state_next.rdata = status_word;
    end else if (reg_req_i.addr == `CONFIG_OFFSET) begin
      state_next.rdata = state_reg.config_word;
    end else begin
      state_next.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= '0;
      state_reg.config_word[`CFG_LIM_MSB:`CFG_LIM_LSB] <= `CFG_LIM_RESET;
      state_reg.config_word[`CFG_REG_MSB:`CFG_REG_LSB] <= `CFG_REG_RESET;
      state_reg.config_word[`CFG_AUTOGRAD_BIT]         <= 1'b1;
      state_reg.config_word[`CFG_AUTOSCALE_BIT]        <= 1'b1;
      state_reg.config_word[`CFG_FREQ_MSB:`CFG_FREQ_LSB] <= `CFG_FREQ_RESET;
      state_reg.config_word[`CFG_OFS_MSB:`CFG_OFS_LSB] <= `CFG_OFS_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata_o           = state_reg.rdata;
  assign amplitude_sum_o       = state_reg.amplitude;
  assign pwm_o                 = state_reg.pwm_level;
  assign pwm_period_start_o    = state_reg.period_start;
  assign standstill_o          = (state_reg.idle_count >= STANDSTILL_CLOCKS);
  assign freewheel_mode_o      = state_reg.config_word[`CFG_FREEWHEEL_MSB:`CFG_FREEWHEEL_LSB];
  assign autoscale_o           = state_reg.config_word[`CFG_AUTOSCALE_BIT];
  assign autograd_o            = state_reg.config_word[`CFG_AUTOGRAD_BIT];
  assign regulation_gradient_o = state_reg.config_word[`CFG_REG_MSB:`CFG_REG_LSB];
  assign switch_on_limit_o     = state_reg.config_word[`CFG_LIM_MSB:`CFG_LIM_LSB];

endmodule

//--- sim/pwm_monitor.sv
`timescale 1ns/100ps
module pwm_monitor #(
  parameter logic [20:0] STANDSTILL_CLOCKS = 21'h00_0040
) (
  input wire logic                       mclk_i,
  input wire logic                       reset_i,
  input wire quiet_pwm_pkg::reg_req_type reg_req_i,
  input wire logic [31:0]                reg_rdata_o,
  input wire logic                       step_pulse_i,
  input wire logic                       quiet_chopper_active_i,
  input wire logic [4:0]                 current_scale_i,
  input wire logic [7:0]                 amplitude_sum_o,
  input wire logic                       pwm_period_start_o,
  input wire logic                       standstill_o,
  input wire logic                       autoscale_o
);
  // pin-quiet count runs two edges ahead of the synced step detect
  logic [20:0] calm_reg;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) calm_reg <= '0;
    else if (step_pulse_i) calm_reg <= '0;
    else if (calm_reg != 21'h1f_ffff) calm_reg <= calm_reg + 21'h00_0001;
  end
  // clocks since the last period pulse, and since the last config write
  logic [10:0] gap_cnt;
  logic [10:0] cfg_age;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) gap_cnt <= '0;
    else if (pwm_period_start_o) gap_cnt <= '0;
    else if (gap_cnt != 11'h7ff) gap_cnt <= gap_cnt + 11'h001;
  end
  // a frequency change may shorten one period, so the floor waits for a settled code
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) cfg_age <= '0;
    else if (reg_req_i.wr && reg_req_i.addr == 7'h70) cfg_age <= '0;
    else if (cfg_age != 11'h7ff) cfg_age <= cfg_age + 11'h001;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  property p_sts_fields;
    !$past(reset_i) && $past(reg_req_i.addr) == 7'h6f |-> reg_rdata_o[30:16] ==
      {$past(quiet_chopper_active_i), 9'h000, $past(current_scale_i)};
  endproperty
  a_sts_fields: assert property (p_sts_fields) else $error("status field mismatch");
  property p_sts_rsvd;
    !$past(reset_i) && $past(reg_req_i.addr) == 7'h6f |->
      reg_rdata_o[15:12] == 4'h0 && reg_rdata_o[9:0] == 10'h000;
  endproperty
  a_sts_rsvd: assert property (p_sts_rsvd) else $error("status spare bits set");
  property p_cfg_read;
    !$past(reset_i) && $past(reg_req_i.addr) == 7'h70 |-> reg_rdata_o[18] == $past(autoscale_o);
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config readback mismatch");
  property p_unmapped;
    !$past(reset_i) && !($past(reg_req_i.addr) inside {7'h6f, 7'h70}) |-> reg_rdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_period;
    (gap_cnt <= 11'h208) &&
      (!(pwm_period_start_o && cfg_age > 11'h44c) || gap_cnt >= 11'h0cb);
  endproperty
  a_period: assert property (p_period) else $error("period pulse spacing wrong");
  property p_amp_hold;
    !$past(pwm_period_start_o) |-> $stable(amplitude_sum_o);
  endproperty
  a_amp_hold: assert property (p_amp_hold) else $error("amplitude moved mid period");
  property p_stst_clr;
    $rose(step_pulse_i) |-> ##[1:4] !standstill_o;
  endproperty
  a_stst_clr: assert property (p_stst_clr) else $error("standstill kept after step");
  property p_stst_early;
    $rose(standstill_o) |-> calm_reg >= STANDSTILL_CLOCKS;
  endproperty
  a_stst_early: assert property (p_stst_early) else $error("standstill too early");
  property p_stst_set;
    calm_reg == STANDSTILL_CLOCKS + 21'h00_0006 |-> standstill_o;
  endproperty
  a_stst_set: assert property (p_stst_set) else $error("standstill missing");
  c_period: cover property (pwm_period_start_o);
  c_stst: cover property ($rose(standstill_o));
  c_write: cover property (reg_req_i.wr && reg_req_i.addr == 7'h70);
endmodule
bind quiet_pwm_amplitude_and_status pwm_monitor #(.STANDSTILL_CLOCKS(STANDSTILL_CLOCKS)) mon (.*);

//--- sim/motor_side_model.sv
`timescale 1ns/100ps
module motor_side_model (
  input  wire logic [7:0] step_gap_i,
  input  wire logic       mclk_i,
  input  wire logic [1:0] heat_i,
  output logic            step_pulse_o,
  output logic            temp_high_o,
  output logic            temp_mid_o
);
  logic [7:0] gap_reg = 8'h00;
  initial step_pulse_o = 1'b0;
  // gap of zero parks the step pin low
  always @(negedge mclk_i) begin
    gap_reg <= (gap_reg >= step_gap_i) ? 8'h01 : gap_reg + 8'h01;
    step_pulse_o <= (step_gap_i != 8'h00) && (gap_reg >= step_gap_i);
  end
  // the hotter comparator implies the cooler one
  assign temp_high_o = heat_i == 2'h2;
  assign temp_mid_o  = heat_i != 2'h0;
endmodule

//--- sim/tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin $display("CHECK FAILED %s exp %h got %h", n, e, a); err_total++; end end
module tb_top;
  logic                       mclk_i = 1'b0;
  logic                       reset_i = 1'b1;
  quiet_pwm_pkg::reg_req_type req = '0;
  logic [31:0]                rdata;
  logic [31:0]                v;
  logic                       step;
  logic                       t_high;
  logic                       t_mid;
  logic                       quiet = 1'b0;
  logic [4:0]                 cs = 5'h00;
  logic [7:0]                 auto_amp = 8'h05;
  logic [7:0]                 amp;
  logic                       p_start;
  logic [7:0]                 gap = 8'h00;
  logic [1:0]                 heat = 2'h0;
  int                         err_total = 0;
  int                         n_tests = 0;
  int                         n;
  int                         lens[4] = '{1024, 683, 512, 410};
  always #25 mclk_i = ~mclk_i;
  motor_side_model coil (.step_gap_i(gap), .mclk_i(mclk_i), .heat_i(heat),
    .step_pulse_o(step), .temp_high_o(t_high), .temp_mid_o(t_mid));
  quiet_pwm_amplitude_and_status #(.STANDSTILL_CLOCKS(21'h00_0040)) dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .step_pulse_i(step), .temp_high_flag_i(t_high), .temp_mid_flag_i(t_mid),
    .otp_gradient_i(8'h0e), .quiet_chopper_active_i(quiet), .current_scale_i(cs),
    .auto_amplitude_i(auto_amp), .amplitude_sum_o(amp), .pwm_o(),
    .pwm_period_start_o(p_start), .standstill_o(), .freewheel_mode_o(), .autoscale_o(),
    .autograd_o(), .regulation_gradient_o(), .switch_on_limit_o());
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(negedge mclk_i);
    req <= '{addr: a, wr: 1'b1, wdata: d};
    @(negedge mclk_i);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [31:0] d);
    @(negedge mclk_i);
    req <= '{addr: a, wr: 1'b0, wdata: 32'h0000_0000};
    @(negedge mclk_i);
    d = rdata;
  endtask
  // cycles across two wraps equal the period length even for odd lengths
  task automatic span(output int c);
    int k;
    c = 0;
    k = 0;
    do @(negedge mclk_i); while (p_start !== 1'b1);
    while (k < 2) begin
      @(negedge mclk_i);
      c++;
      if (p_start === 1'b1) k++;
    end
  endtask
  task automatic amp_chk(input logic [31:0] cfg, input logic [7:0] e);
    wr(7'h70, cfg);
    repeat (2) span(n);
    repeat (2) @(negedge mclk_i);
    `CHK("amplitude", e, amp)
  endtask
  task automatic complete_run();
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge mclk_i);
    reset_i <= 1'b0;
    repeat (2) @(negedge mclk_i);
    rd(7'h70, v);
    `CHK("config reset", 32'hc40d_0e24, v)
    for (int c = 0; c < 4; c++) begin
      wr(7'h70, {14'h0000, c[1:0], 16'h0000});
      span(n);
      `CHK("pwm period", lens[c], n)
    end
    cs <= 5'h0f;
    gap <= 8'h20;
    amp_chk(32'h0003_0840, 8'h60);
    cs <= 5'h1f;
    amp_chk(32'h0003_ffff, 8'hff);
    amp_chk(32'h0007_0800, 8'h10);
    amp_chk(32'h0007_0801, 8'h05);
    gap <= 8'h00;
    heat <= 2'h2;
    quiet <= 1'b1;
    cs <= 5'h15;
    repeat (80) @(negedge mclk_i);
    rd(7'h6f, v);
    `CHK("status idle", 32'hc015_0c00, v)
    wr(7'h6f, 32'hffff_ffff);
    gap <= 8'h20;
    heat <= 2'h1;
    quiet <= 1'b0;
    cs <= 5'h03;
    repeat (40) @(negedge mclk_i);
    rd(7'h6f, v);
    `CHK("status moving", 32'h0003_0400, v)
    rd(7'h70, v);
    `CHK("config kept", 32'h0007_0801, v)
    rd(7'h55, v);
    `CHK("unmapped", 32'h0000_0000, v)
    complete_run();
  end
  initial begin
    #2_000_000;
    err_total++;
    complete_run();
  end
endmodule
